// ===== rsp_consts.vh
// constants of the rtc spi register port
// assumes inclusion by the port, its checker and its bench, plain verilog-2005
`ifndef RSP_CONSTS_VH
`define RSP_CONSTS_VH
// timing
`define RSP_CLK_PERIOD_NS    4
`define RSP_VDD_SETTLE_MS    40
`define RSP_VDD_SETTLE_CYC   ((`RSP_VDD_SETTLE_MS * 1000000 + `RSP_CLK_PERIOD_NS - 1) / `RSP_CLK_PERIOD_NS)
`define RSP_SER_RATE_KBPS    4000
// serial word
`define RSP_WORD_BITS        8
`define RSP_CMD_RW_BIT       7
`define RSP_ADDR_LAST        7'h6f
// flag register and bit positions
`define RSP_FLAG_ADDR        7'h0e
`define RSP_FLAG_OSCSTP_BIT  1
`define RSP_FLAG_VLOW_BIT    0
// mode codes, one-hot
`define RSP_MODE_OFF         5'h01
`define RSP_MODE_STANDBY     5'h02
`define RSP_MODE_INIT        5'h04
`define RSP_MODE_NORMAL      5'h08
`define RSP_MODE_BACKUP      5'h10
// reset values
`define RSP_CNT_RST          24'h000000
`define RSP_BYTE_RST         8'h00
`define RSP_ADDR_RST         7'h00
`endif

// ===== rsp_buf2.v
// two-entry valid/ready buffer for received write words
// assumes one clock, producer and consumer on clk
`timescale 1ns/100ps
module rsp_buf2 (
  input  wire        clk,       // system clock
  input  wire        rstn,      // async reset, active low
  input  wire [14:0] in_data,   // address and data
  input  wire        in_valid,  // word offered
  output wire        in_ready,  // room available
  output wire [14:0] out_data,  // oldest word
  output wire        out_valid, // word present
  input  wire        out_ready  // consumer takes word
);
  reg [14:0] mem_q [0:1];
  reg        wp_q;
  reg        rp_q;
  reg [1:0]  cnt_q;
  wire       push = in_valid && in_ready;
  wire       pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= 15'h0000;
      mem_q[1] <= 15'h0000;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q        <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ===== rsp_port.v
// spi slave register port of a real time clock with operating-mode control
// assumes supply comparators and oscillator status arrive as async levels
`timescale 1ns/100ps
`include "rsp_consts.vh"
module rsp_port #(
  parameter        FOUR_WIRE  = 0,                    // 0: 3-wire, 1: 4-wire
  parameter [23:0] SETTLE_CYC = `RSP_VDD_SETTLE_CYC   // main supply settle count
) (
  input  wire       clk,              // system clock, 250 MHz
  input  wire       rstn,             // async reset, active low
  input  wire       sel_in,           // slave select pin, active high
  input  wire       sclk_in,          // serial clock pin, idles high
  input  wire       serial_data_in,   // 4-wire data input pin
  input  wire       sdb_in,           // serial_data_bidir pin level
  output reg        sdb_out,          // serial_data_bidir drive value
  output reg        sdb_oe,           // serial_data_bidir drive enable
  output reg        sdo_out,          // 4-wire data output value
  output reg        sdo_oe,           // 4-wire data output enable
  input  wire       backup_supply_ok, // backup supply above low level
  input  wire       main_rise_ok,     // main above main_supply_rise_level
  input  wire       main_fall_low,    // main at or below main_supply_fall_level
  input  wire       backup_clk_ok,    // backup supply at or above timekeeping level
  input  wire       osc_stop_det,     // oscillation stop detected
  input  wire       backup_tr_en,     // backup transition enabled
  output reg        osc_enable,       // 32 kHz oscillator run
  output reg        main_isolation_switch, // isolate main from backup
  output reg        auto_switch_en,   // automatic power switching on
  output reg        counter_access,   // calendar counters readable and settable
  output reg        timekeep_run,     // calendar, events and interrupt active
  output reg        frequency_clock_out_oe,          // frequency_clock_out drive enable
  output reg        oscillation_stop_flag, // flag, set by hardware
  output reg        voltage_low_flag, // flag, set by hardware
  output reg  [4:0] mode_q,           // operating mode, one-hot
  output reg        wr_valid,         // register write strobe
  output reg  [6:0] wr_addr,          // register write address
  output reg  [7:0] wr_data,          // register write data
  output reg  [6:0] rd_addr,          // register read address
  input  wire [7:0] rd_data           // register read data, same clock
);
  localparam MODE_OFF     = `RSP_MODE_OFF;
  localparam MODE_STANDBY = `RSP_MODE_STANDBY;
  localparam MODE_INIT    = `RSP_MODE_INIT;
  localparam MODE_NORMAL  = `RSP_MODE_NORMAL;
  localparam MODE_BACKUP  = `RSP_MODE_BACKUP;

  // ==========================================================
  // input synchronisers
  // ==========================================================
  localparam NSYNC = 9;
  wire [NSYNC-1:0] async_in = {osc_stop_det, backup_clk_ok, main_fall_low, main_rise_ok,
                               backup_supply_ok, sdb_in, serial_data_in, sclk_in, sel_in};
  reg  [NSYNC-1:0] s1_q;
  reg  [NSYNC-1:0] s2_q;
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= async_in[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate
  wire sel_s   = s2_q[0];
  wire sclk_s  = s2_q[1];
  wire din_s   = FOUR_WIRE ? s2_q[2] : s2_q[3];
  wire bat_s   = s2_q[4];
  wire rise_s  = s2_q[5];
  wire fall_s  = s2_q[6];
  wire vclk_s  = s2_q[7];
  wire ostop_s = s2_q[8];

  // ==========================================================
  // operating mode
  // ==========================================================
  reg  [23:0] settle_q;
  wire        settled = (settle_q >= SETTLE_CYC);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q   <= MODE_OFF;
      settle_q <= `RSP_CNT_RST;
    end else begin
      settle_q <= (rise_s && !settled) ? settle_q + 24'h000001 : (rise_s ? settle_q : `RSP_CNT_RST);
      case (mode_q)
        MODE_OFF: begin
          if (bat_s && !rise_s)
            mode_q <= MODE_STANDBY;
          else if (settled)
            mode_q <= MODE_INIT;
        end
        MODE_STANDBY: begin
          if (settled)
            mode_q <= MODE_INIT;
        end
        MODE_INIT: begin
          if (!ostop_s)
            mode_q <= MODE_NORMAL;
        end
        MODE_NORMAL: begin
          if (backup_tr_en && fall_s)
            mode_q <= MODE_BACKUP;
        end
        MODE_BACKUP: begin
          if (settled && !fall_s)
            mode_q <= ostop_s ? MODE_INIT : MODE_NORMAL;
        end
        default: mode_q <= MODE_OFF;
      endcase
    end
  end

  wire host_ok = (mode_q == MODE_INIT) || (mode_q == MODE_NORMAL);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_enable            <= 1'b0;
      main_isolation_switch <= 1'b0;
      auto_switch_en        <= 1'b0;
      counter_access        <= 1'b0;
      timekeep_run          <= 1'b0;
      frequency_clock_out_oe               <= 1'b0;
    end else begin
      osc_enable            <= (mode_q != MODE_OFF);
      main_isolation_switch <= (mode_q == MODE_BACKUP);
      auto_switch_en        <= (mode_q == MODE_NORMAL) && backup_tr_en;
      counter_access        <= (mode_q == MODE_NORMAL) && !ostop_s;
      timekeep_run          <= (mode_q == MODE_NORMAL) || (mode_q == MODE_INIT) ||
                               ((mode_q == MODE_BACKUP) && vclk_s);
      frequency_clock_out_oe               <= (mode_q == MODE_NORMAL);
    end
  end

  // ==========================================================
  // serial shifter, mode 3 timing
  // ==========================================================
  reg        sclk_q;
  reg  [2:0] bit_q;
  reg  [7:0] sh_q;
  reg        have_cmd_q;
  reg        rd_mode_q;
  reg  [7:0] tx_q;
  reg        tx_on_q;
  wire       active = sel_s && host_ok;
  wire       rise   = active && sclk_s && !sclk_q;
  wire       fall   = active && !sclk_s && sclk_q;
  wire [7:0] byte_in = {sh_q[6:0], din_s};
  wire       byte_end = rise && (bit_q == 3'h7);
  wire       buf_ready;
  wire       buf_valid;
  wire [14:0] buf_data;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_q     <= 1'b1;
      bit_q      <= 3'h0;
      sh_q       <= `RSP_BYTE_RST;
      have_cmd_q <= 1'b0;
      rd_mode_q  <= 1'b0;
      rd_addr    <= `RSP_ADDR_RST;
      tx_q       <= `RSP_BYTE_RST;
      tx_on_q    <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
      if (!active) begin
        bit_q      <= 3'h0;
        have_cmd_q <= 1'b0;
        rd_mode_q  <= 1'b0;
        tx_on_q    <= 1'b0;
      end else begin
        if (rise && !(have_cmd_q && rd_mode_q))
          sh_q <= byte_in;
        if (rise)
          bit_q <= bit_q + 3'h1;
        if (byte_end && !have_cmd_q) begin
          have_cmd_q <= 1'b1;
          rd_mode_q  <= byte_in[`RSP_CMD_RW_BIT];
          rd_addr    <= byte_in[6:0];
        end else if (byte_end)
          rd_addr <= {rd_addr[6:4], rd_addr[3:0] + 4'h1};
        if (fall && have_cmd_q && rd_mode_q) begin
          tx_on_q <= 1'b1;
          if (bit_q == 3'h0)
            tx_q <= rd_data;
          else
            tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // write words go through the buffer; out_ready is tied high, so it never fills and drops no word
  wire wr_push = byte_end && have_cmd_q && !rd_mode_q;
  rsp_buf2 u_buf (
    .clk       (clk),
    .rstn      (rstn),
    .in_data   ({rd_addr, byte_in}),
    .in_valid  (wr_push),
    .in_ready  (buf_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (1'b1)
  );

  // ==========================================================
  // register write port and flags
  // ==========================================================
  wire flag_wr = buf_valid && (buf_data[14:8] == `RSP_FLAG_ADDR);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_valid              <= 1'b0;
      wr_addr               <= `RSP_ADDR_RST;
      wr_data               <= `RSP_BYTE_RST;
      oscillation_stop_flag <= 1'b0;
      voltage_low_flag      <= 1'b0;
    end else begin
      wr_valid <= buf_valid;
      wr_addr  <= buf_data[14:8];
      wr_data  <= buf_data[7:0];
      // set wins over clear; clear only once stop detect is gone
      if (ostop_s || mode_q == MODE_INIT || mode_q == MODE_OFF) begin
        oscillation_stop_flag <= osc_enable;
        voltage_low_flag      <= osc_enable;
      end else if (flag_wr) begin
        if (!buf_data[`RSP_FLAG_OSCSTP_BIT])
          oscillation_stop_flag <= 1'b0;
        if (!buf_data[`RSP_FLAG_VLOW_BIT])
          voltage_low_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // data outputs
  // ==========================================================
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sdb_out <= 1'b0;
      sdb_oe  <= 1'b0;
      sdo_out <= 1'b0;
      sdo_oe  <= 1'b0;
    end else begin
      sdb_out <= tx_q[7];
      sdo_out <= tx_q[7];
      sdb_oe  <= !FOUR_WIRE && tx_on_q && active;
      sdo_oe  <= FOUR_WIRE && tx_on_q && active;
    end
  end
endmodule

// ===== rsp_port_sva.sv
// checker for the rtc spi register port
// assumes bind into rsp_port, one clock domain
`timescale 1ns/100ps
`include "rsp_consts.vh"
module rsp_port_sva (
  input wire logic       clk,                   // clock
  input wire logic       rstn,                  // reset
  input wire logic       sel_in,                // select
  input wire logic       sdb_oe,                // bidir enable
  input wire logic       sdo_oe,                // out enable
  input wire logic       backup_clk_ok,         // backup level
  input wire logic       main_fall_low,         // main low
  input wire logic       backup_tr_en,          // backup enable
  input wire logic       osc_enable,            // oscillator
  input wire logic       main_isolation_switch, // isolation
  input wire logic       auto_switch_en,        // auto switch
  input wire logic       counter_access,        // counters open
  input wire logic       timekeep_run,          // timekeeping
  input wire logic       frequency_clock_out_oe,               // freq enable
  input wire logic       oscillation_stop_flag, // flag
  input wire logic       voltage_low_flag,      // flag
  input wire logic [4:0] mode_q,                // mode
  input wire logic       wr_valid,              // write strobe
  input wire logic [6:0] wr_addr                // write address
);
  reg [6:0] last_q;
  reg       have_q;
  // ========
  // last write address within the current frame
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_q <= 7'h00;
      have_q <= 1'b0;
    end else if (!sel_in) begin
      have_q <= 1'b0;
    end else if (wr_valid) begin
      last_q <= wr_addr;
      have_q <= 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_fall; $rose(main_fall_low) && backup_tr_en && mode_q == `RSP_MODE_NORMAL; endsequence
  sequence s_bk; (mode_q == `RSP_MODE_BACKUP && backup_clk_ok)[*6]; endsequence
  property p_standby; (mode_q == `RSP_MODE_STANDBY)[*2] |-> osc_enable && !counter_access && !wr_valid; endproperty
  a_standby: assert property (p_standby) else $error("standby state wrong");
  property p_init_lock; (mode_q == `RSP_MODE_INIT)[*2] |-> !counter_access; endproperty
  a_init_lock: assert property (p_init_lock) else $error("counters open in initial mode");
  property p_init_flags; (mode_q == `RSP_MODE_INIT)[*2] |-> oscillation_stop_flag && voltage_low_flag; endproperty
  a_init_flags: assert property (p_init_flags) else $error("flags clear in initial mode");
  property p_normal; (mode_q == `RSP_MODE_NORMAL && !backup_tr_en)[*2] |-> counter_access && !auto_switch_en; endproperty
  a_normal: assert property (p_normal) else $error("normal mode state wrong");
  property p_to_backup; s_fall |-> ##[1:8] mode_q == `RSP_MODE_BACKUP; endproperty
  a_to_backup: assert property (p_to_backup) else $error("no move to backup");
  property p_bk_float; (mode_q == `RSP_MODE_BACKUP)[*2] |-> !sdb_oe && !sdo_oe && !frequency_clock_out_oe && main_isolation_switch && !wr_valid; endproperty
  a_bk_float: assert property (p_bk_float) else $error("backup pins not released");
  property p_bk_time; s_bk |-> timekeep_run; endproperty
  a_bk_time: assert property (p_bk_time) else $error("timekeeping stopped in backup");
  property p_addr_step; wr_valid && have_q |-> wr_addr == {last_q[6:4], last_q[3:0] + 4'h1}; endproperty
  a_addr_step: assert property (p_addr_step) else $error("write address step wrong");
  property p_desel; (!sel_in)[*8] |-> !sdb_oe && !sdo_oe; endproperty
  a_desel: assert property (p_desel) else $error("data driven while deselected");
endmodule
bind rsp_port rsp_port_sva i_sva (.*);

// ===== rsp_host.sv
// spi host model for the rtc register port
// assumes the caller starts just after a clk edge
`timescale 1ns/100ps
module rsp_host (
  output reg  sel,  // slave select
  output reg  sclk, // serial clock
  output reg  dout, // data to device
  output reg  doe,  // data drive enable
  input  wire din   // data pin level
);
  localparam integer HALF = 40;
  initial begin
    sel = 1'b0;
    sclk = 1'b1;
    dout = 1'b0;
    doe = 1'b0;
  end
  task start;
    begin
      sel = 1'b1;
      #HALF;
    end
  endtask
  task stop;
    begin
      #HALF;
      sel = 1'b0;
      doe = 1'b0;
      #(4 * HALF);
    end
  endtask
  task xbyte(input [7:0] tx, input integer n, input drv, output [7:0] rx);
    integer k;
    begin
      rx = 8'h00;
      for (k = 7; k > 7 - n; k--) begin
        sclk = 1'b0;
        doe = drv;
        dout = tx[k];
        #HALF;
        sclk = 1'b1;
        rx[k] = din;
        #HALF;
      end
    end
  endtask
endmodule

// ===== test_rtc_spi_register_port.sv
// self-checking bench for the rtc spi register port
// assumes 3-wire build and a short settle count
`timescale 1ns/100ps
`include "rsp_consts.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module test_rtc_spi_register_port;
  reg        clk = 1'b0;
  reg        rstn = 1'b0;
  reg        bk_ok = 1'b0, rise_ok = 1'b0, fall_low = 1'b0, clk_ok = 1'b0, stop_det = 1'b0, tr_en = 1'b0;
  reg        noise = 1'b0;
  wire       h_sel, h_sclk, h_dout, h_doe, sdb_out, sdb_oe, frequency_clock_out_oe, iso, wr_valid, osc_en, osf, vlf, ca, asw, tk;
  wire [4:0] mode_q;
  wire [6:0] wr_addr, rd_addr;
  wire [7:0] wr_data;
  wire       sel_w = (h_sel === 1'b1);
  wire       pin = sdb_oe ? sdb_out : (h_doe ? h_dout : noise);
  wire [7:0] rd_data = exp_rd(rd_addr);
  integer    n_errors = 0, checks_done = 0, i, j, n;
  reg [14:0] wq[$];
  reg [7:0]  wd[0:3];
  reg [7:0]  rx;
  reg [6:0]  a;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    noise <= #1 ~noise;
    if (wr_valid) wq.push_back({wr_addr, wr_data});
  end
  rsp_port #(.FOUR_WIRE(0), .SETTLE_CYC(24'h000014)) i_dut (
    .clk(clk), .rstn(rstn), .sel_in(sel_w), .sclk_in(h_sclk), .serial_data_in(noise), .sdb_in(pin),
    .sdb_out(sdb_out), .sdb_oe(sdb_oe), .sdo_out(), .sdo_oe(), .backup_supply_ok(bk_ok), .main_rise_ok(rise_ok),
    .main_fall_low(fall_low), .backup_clk_ok(clk_ok), .osc_stop_det(stop_det), .backup_tr_en(tr_en),
    .osc_enable(osc_en), .main_isolation_switch(iso), .auto_switch_en(asw), .counter_access(ca),
    .timekeep_run(tk), .frequency_clock_out_oe(frequency_clock_out_oe), .oscillation_stop_flag(osf), .voltage_low_flag(vlf), .mode_q(mode_q),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data));
  rsp_host i_host (.sel(h_sel), .sclk(h_sclk), .dout(h_dout), .doe(h_doe), .din(pin));
  // ========
  // expectations and transfers
  function [7:0] exp_rd(input [6:0] ad);
    exp_rd = {ad[3:0], ad[6:3]} ^ 8'h3c;
  endfunction
  function [6:0] nxt(input [6:0] ad, input integer k);
    nxt = {ad[6:4], ad[3:0] + k[3:0]};
  endfunction
  task wt(input integer c);
    begin
      repeat (c) @(posedge clk);
      #1;
    end
  endtask
  task frame(input [7:0] cmd, input integer nb, input integer part, input rd);
    integer k;
    begin
      wq.delete();
      wt(1);
      i_host.start();
      i_host.xbyte(cmd, 8, 1'b1, rx);
      for (k = 0; k < nb; k++) begin
        i_host.xbyte(wd[k], 8, !rd, rx);
        if (rd) `CHK(rx, exp_rd(nxt(cmd[6:0], k)))
      end
      if (part > 0) i_host.xbyte(8'ha5, part, 1'b1, rx);
      i_host.stop();
    end
  endtask
  task chk_wr(input [6:0] ad, input integer nb);
    integer k;
    begin
      `CHK(wq.size(), nb)
      for (k = 0; k < nb && k < wq.size(); k++) `CHK(wq[k], {nxt(ad, k), wd[k]})
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #350000;
    n_errors++;
    finish_test;
  end
  initial begin
    void'($urandom(49876));
    wt(4);
    rstn = 1'b1;
    `CHK(mode_q, `RSP_MODE_OFF)
    bk_ok = 1'b1;
    wt(10);
    `CHK({mode_q, osc_en}, {`RSP_MODE_STANDBY, 1'b1})
    wd[0] = 8'h5a;
    frame(8'h05, 1, 0, 0);
    chk_wr(7'h05, 0);
    rise_ok = 1'b1;
    stop_det = 1'b1;
    wt(40);
    `CHK({mode_q, osf, vlf}, {`RSP_MODE_INIT, 2'b11})
    wd[0] = 8'h00;
    frame({1'b0, `RSP_FLAG_ADDR}, 1, 0, 0);
    `CHK({osf, vlf, ca}, 3'b110)
    stop_det = 1'b0;
    wt(10);
    `CHK({mode_q, ca, asw}, {`RSP_MODE_NORMAL, 2'b10})
    frame({1'b0, `RSP_FLAG_ADDR}, 1, 0, 0);
    `CHK({osf, vlf}, 2'b00)
    for (i = 0; i < 6; i++) begin
      a = (i == 0) ? 7'h6f : {3'($urandom % 7), 4'($urandom)};
      for (j = 0; j < 4; j++) wd[j] = 8'($urandom);
      n = (i == 4) ? 0 : 1 + $urandom % 4;
      frame({1'b0, a}, n, (i >= 4) ? i - 1 : 0, 0);
      chk_wr(a, n);
    end
    for (i = 0; i < 4; i++) frame({1'b1, (i == 0) ? 7'h2e : {3'($urandom % 7), 4'($urandom)}}, 3, 0, 1);
    tr_en = 1'b1;
    clk_ok = 1'b1;
    fall_low = 1'b1;
    wt(12);
    `CHK({mode_q, sdb_oe, frequency_clock_out_oe, iso, tk}, {`RSP_MODE_BACKUP, 4'b0011})
    frame(8'h10, 1, 0, 0);
    chk_wr(7'h10, 0);
    fall_low = 1'b0;
    wt(40);
    `CHK(mode_q, `RSP_MODE_NORMAL)
    finish_test;
  end
endmodule
